//--- addr_select_pkg.sv
// Constants and types for the segment and I/O address select block.
// Assumes a single processor clock; decode supplies request strobes.
// Function
// - Separate I/O space, 64K byte or 32K word ports
// - Port address from 8-bit immediate or data_count_reg
// - Immediate port address zero-extended, upper lines low
// - Unqualified data references default to data segment
// - Instruction fetches always use code segment
// - Stack and base-pointer references use stack segment
// - String destination-index references use extra segment; code lets override or base pointer (stack segment) win
// - Override prefix replaces implied segment register
// - Signed arithmetic is two's complement
// - Packed decimal: one digit per nibble
// - Unpacked decimal: one digit per byte
// - Strings span one byte up to 64 Kbytes
// - Doubleword held as data_count_reg high, accumulator low
// - Halt stops execution until interrupt or reset
// - Flag store writes only sign, zero, aux, parity, carry
// - Test ANDs, sets flags, discards result
// - Physical address is segment shifted four plus offset
package addr_select_pkg;

  localparam int SEG_W        = 16;
  localparam int OFS_W        = 16;
  localparam int PHYS_W       = 20;
  localparam int SEG_SHIFT    = 4;
  localparam int PORT_W       = 16;
  localparam int PORT_IMM_W   = 8;
  localparam int STR_MAX_LEN  = 65536;
  localparam int DIGIT_W      = 4;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  localparam logic [PORT_W-1:0] PORT_RSVD_LO = 16'h00f8;
  localparam logic [PORT_W-1:0] PORT_RSVD_HI = 16'h00ff;

  // Flag bit positions in the 16-bit status word
  localparam int FLAG_CARRY  = 0;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_AUX    = 4;
  localparam int FLAG_ZERO   = 6;
  localparam int FLAG_SIGN   = 7;
  localparam int FLAG_OVF    = 11;
  localparam logic [15:0] FLAG_STORE_MASK = 16'h00d5;
  localparam logic [15:0] FLAGS_RESET     = 16'h0000;

  // Segment register codes, as carried by an override prefix
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE  = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA  = 2'h3;

  typedef enum logic [3:0] {
    REF_DATA   = 4'h1,
    REF_FETCH  = 4'h2,
    REF_STACK  = 4'h4,
    REF_STRDST = 4'h8
  } ref_kind_t;

  typedef enum logic [2:0] {
    RUN_ST  = 3'h1,
    HALT_ST = 3'h2,
    WAKE_ST = 3'h4
  } run_state_t;

  typedef enum logic [2:0] {
    ALU_ADD  = 3'h0,
    ALU_SUB  = 3'h1,
    ALU_AND  = 3'h2,
    ALU_TEST = 3'h3,
    ALU_STORE_HIGH_ACC_TO_FLAGS = 3'h4,
    ALU_BCD  = 3'h5
  } alu_op_t;

endpackage

//--- seg_reg_file.sv
// Four segment registers with registered read of the selected one.
// Assumes writes come from the execute path on the same clock.
`timescale 1ns/100ps
module seg_reg_file
  import addr_select_pkg::*;
#(
  parameter int WIDTH = SEG_W
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             wr_en_in,
  input  wire logic [1:0]       wr_sel_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic [1:0]       rd_sel_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] seg_mem_reg [4];

  // ==========================================================
  // Storage
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_seg
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          seg_mem_reg[g] <= '0;
        end else if (wr_en_in && wr_sel_in == 2'(g)) begin
          seg_mem_reg[g] <= wr_data_in;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Registered read; write-through keeps a just-written value visible
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= '0;
    end else if (wr_en_in && wr_sel_in == rd_sel_in) begin
      rd_data_out <= wr_data_in;
    end else begin
      rd_data_out <= seg_mem_reg[rd_sel_in];
    end
  end

endmodule

//--- segment_and_io_address_select.sv
// Segment selection, physical and I/O address forming, flag ops, halt.
// Assumes decode presents one request per cycle; port and ALU results one cycle later, memory results two.
`timescale 1ns/100ps
module segment_and_io_address_select
  import addr_select_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // Segment register load path
  input  wire logic              seg_wr_in,
  input  wire logic [1:0]        seg_wr_sel_in,
  input  wire logic [SEG_W-1:0]  seg_wr_data_in,
  // Memory reference request
  input  wire logic              mem_req_in,
  input  wire logic [3:0]        ref_kind_in,
  input  wire logic              uses_base_ptr_in,
  input  wire logic              override_in,
  input  wire logic [1:0]        override_seg_in,
  input  wire logic [OFS_W-1:0]  offset_in,
  // Port request
  input  wire logic              io_req_in,
  input  wire logic              io_use_dcount_in,
  input  wire logic              io_word_in,
  input  wire logic [PORT_IMM_W-1:0] io_imm_in,
  input  wire logic [15:0]       data_count_reg_in,
  // Arithmetic and flag path
  input  wire logic              alu_req_in,
  input  wire logic [2:0]        alu_op_in,
  input  wire logic              alu_word_in,
  input  wire logic [15:0]       alu_a_in,
  input  wire logic [15:0]       alu_b_in,
  input  wire logic [15:0]       accumulator_reg_in,
  // Halt control
  input  wire logic              halt_instruction_in,
  input  wire logic              irq_in,
  // Outputs
  output logic                   mem_valid_out,
  output logic [PHYS_W-1:0]      phys_addr_out,
  output logic [1:0]             seg_used_out,
  output logic                   io_valid_out,
  output logic [PORT_W-1:0]      io_addr_out,
  output logic                   io_word_out,
  output logic                   io_reserved_out,
  output logic                   alu_valid_out,
  output logic [15:0]            alu_result_out,
  output logic                   alu_write_out,
  output logic [15:0]            flags_out,
  output logic [31:0]            dword_out,
  output logic                   bcd_valid_out,
  output logic                   halted_out
);

  logic              irq_meta_reg;
  logic              irq_sync_reg;
  logic [1:0]        seg_sel;
  logic              mem_req_d_reg;
  logic [OFS_W-1:0]  offset_d_reg;
  logic [1:0]        seg_sel_d_reg;
  logic [SEG_W-1:0]  seg_value;
  logic [PHYS_W-1:0] phys_next;
  logic [PORT_W-1:0] port_next;
  logic [15:0]       flags_reg;
  logic [15:0]       flags_next;
  logic [15:0]       res_next;
  logic              write_next;
  logic              carry_next;
  logic              ovf_next;
  logic              aux_next;
  logic              bcd_ok_next;
  logic [16:0]       sum17;
  run_state_t        run_state_reg;
  run_state_t        run_state_next;
  logic              running;

  // ==========================================================
  // Interrupt pin synchroniser
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end else begin
      irq_meta_reg <= irq_in;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // ==========================================================
  // Segment selection
  // Override outranks everything, but fetches always stay on code segment
  always_comb begin
    if (ref_kind_in == REF_FETCH) begin
      seg_sel = SEG_CODE;
    end else if (override_in) begin
      seg_sel = override_seg_in;
    end else if (ref_kind_in == REF_STACK || uses_base_ptr_in) begin
      seg_sel = SEG_STACK;
    end else if (ref_kind_in == REF_STRDST) begin
      seg_sel = SEG_EXTRA;
    end else begin
      seg_sel = SEG_DATA;
    end
  end

  seg_reg_file #(
    .WIDTH (SEG_W)
  ) u_seg (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (seg_wr_in),
    .wr_sel_in   (seg_wr_sel_in),
    .wr_data_in  (seg_wr_data_in),
    .rd_sel_in   (seg_sel),
    .rd_data_out (seg_value)
  );

  // Align offset with the registered segment read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_req_d_reg <= 1'b0;
      offset_d_reg  <= '0;
      seg_sel_d_reg <= SEG_DATA;
    end else begin
      mem_req_d_reg <= mem_req_in && running;
      offset_d_reg  <= offset_in;
      seg_sel_d_reg <= seg_sel;
    end
  end

  // Carry out of bit 19 drops: the space wraps at 1 Mbyte
  assign phys_next = PHYS_W'({seg_value, {SEG_SHIFT{1'b0}}}) + PHYS_W'(offset_d_reg);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_valid_out <= 1'b0;
      phys_addr_out <= '0;
      seg_used_out  <= SEG_DATA;
    end else begin
      mem_valid_out <= mem_req_d_reg;
      phys_addr_out <= phys_next;
      seg_used_out  <= seg_sel_d_reg;
    end
  end

  // ==========================================================
  // Port address
  always_comb begin
    if (io_use_dcount_in) begin
      port_next = data_count_reg_in;
    end else begin
      port_next = {8'h00, io_imm_in};
    end
  end

  // Word ports pair two byte addresses; 16-bit width covers all 64K
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_valid_out    <= 1'b0;
      io_addr_out     <= '0;
      io_word_out     <= 1'b0;
      io_reserved_out <= 1'b0;
    end else begin
      io_valid_out    <= io_req_in && running;
      io_addr_out     <= port_next;
      io_word_out     <= io_word_in;
      // Flagged only; software must keep user ports out of this range
      io_reserved_out <= port_next >= PORT_RSVD_LO && port_next <= PORT_RSVD_HI;
    end
  end

  // ==========================================================
  // Arithmetic and flags
  always_comb begin
    sum17       = 17'h00000;
    res_next    = 16'h0000;
    write_next  = 1'b1;
    carry_next  = flags_reg[FLAG_CARRY];
    ovf_next    = flags_reg[FLAG_OVF];
    aux_next    = flags_reg[FLAG_AUX];
    bcd_ok_next = 1'b0;
    flags_next  = flags_reg;
    case (alu_op_in)
      ALU_ADD: begin
        sum17      = {1'b0, alu_a_in} + {1'b0, alu_b_in};
        res_next   = sum17[15:0];
        carry_next = alu_word_in ? sum17[16] : (alu_a_in[8] ^ alu_b_in[8] ^ sum17[8]);
        aux_next   = alu_a_in[4] ^ alu_b_in[4] ^ sum17[4];
        ovf_next   = alu_word_in ?
                     (alu_a_in[15] == alu_b_in[15]) && (sum17[15] != alu_a_in[15]) :
                     (alu_a_in[7] == alu_b_in[7]) && (sum17[7] != alu_a_in[7]);
      end
      ALU_SUB: begin
        sum17      = {1'b0, alu_a_in} - {1'b0, alu_b_in};
        res_next   = sum17[15:0];
        carry_next = alu_word_in ? sum17[16] : (alu_a_in[8] ^ alu_b_in[8] ^ sum17[8]);
        aux_next   = alu_a_in[4] ^ alu_b_in[4] ^ sum17[4];
        ovf_next   = alu_word_in ?
                     (alu_a_in[15] != alu_b_in[15]) && (sum17[15] != alu_a_in[15]) :
                     (alu_a_in[7] != alu_b_in[7]) && (sum17[7] != alu_a_in[7]);
      end
      ALU_AND, ALU_TEST: begin
        res_next   = alu_a_in & alu_b_in;
        write_next = alu_op_in == ALU_AND;
        carry_next = 1'b0;
        ovf_next   = 1'b0;
      end
      ALU_BCD: begin
        res_next    = alu_a_in;
        write_next  = 1'b0;
        // Byte holds two packed digits; low nibble alone is the unpacked form
        bcd_ok_next = alu_word_in ?
                      (alu_a_in[7:4] <= DIGIT_MAX && alu_a_in[3:0] <= DIGIT_MAX) :
                      (alu_a_in[7:0] <= {4'h0, DIGIT_MAX});
      end
      default: begin
        write_next = 1'b0;
      end
    endcase
    if (alu_op_in == ALU_STORE_HIGH_ACC_TO_FLAGS) begin
      flags_next = (flags_reg & ~FLAG_STORE_MASK) |
                   ({8'h00, accumulator_reg_in[15:8]} & FLAG_STORE_MASK);
    end else if (alu_op_in != ALU_BCD) begin
      flags_next[FLAG_CARRY]  = carry_next;
      flags_next[FLAG_AUX]    = aux_next;
      flags_next[FLAG_OVF]    = ovf_next;
      flags_next[FLAG_SIGN]   = alu_word_in ? res_next[15] : res_next[7];
      flags_next[FLAG_ZERO]   = alu_word_in ? (res_next == 16'h0000) : (res_next[7:0] == 8'h00);
      flags_next[FLAG_PARITY] = ~^res_next[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_reg      <= FLAGS_RESET;
      alu_valid_out  <= 1'b0;
      alu_result_out <= '0;
      alu_write_out  <= 1'b0;
      bcd_valid_out  <= 1'b0;
    end else if (alu_req_in && running) begin
      flags_reg      <= flags_next;
      alu_valid_out  <= 1'b1;
      alu_result_out <= res_next;
      alu_write_out  <= write_next;
      bcd_valid_out  <= bcd_ok_next;
    end else begin
      alu_valid_out  <= 1'b0;
      alu_write_out  <= 1'b0;
      bcd_valid_out  <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_out <= FLAGS_RESET;
      dword_out <= '0;
    end else begin
      // Mirrors flags_reg, so refused requests never show on the port
      flags_out <= (alu_req_in && running) ? flags_next : flags_reg;
      dword_out <= {data_count_reg_in, accumulator_reg_in};
    end
  end

  // ==========================================================
  // Halt sequencer
  // Wake already takes requests, so refusal matches halted_out exactly
  assign running = run_state_reg != HALT_ST;

  always_comb begin
    case (run_state_reg)
      RUN_ST:  run_state_next = halt_instruction_in ? HALT_ST : RUN_ST;
      HALT_ST: run_state_next = irq_sync_reg ? WAKE_ST : HALT_ST;
      WAKE_ST: run_state_next = halt_instruction_in ? HALT_ST : RUN_ST;
      default: run_state_next = RUN_ST;
    endcase
  end

  // Reset also leaves halt since it restores RUN_ST
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_state_reg <= RUN_ST;
      halted_out    <= 1'b0;
    end else begin
      run_state_reg <= run_state_next;
      halted_out    <= run_state_next == HALT_ST;
    end
  end

  // String length spans 1..STR_MAX_LEN; offset wrap above is the only limit

endmodule

//--- addr_select_monitor.sv
// Port checker for the segment and I/O address select block.
// Assumes binding to the top module; one clock, async low reset.
`timescale 1ns/100ps
module addr_select_monitor
  import addr_select_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        mem_req_in,
  input wire logic [3:0]  ref_kind_in,
  input wire logic        uses_base_ptr_in,
  input wire logic        override_in,
  input wire logic [1:0]  override_seg_in,
  input wire logic        io_req_in,
  input wire logic        io_use_dcount_in,
  input wire logic [7:0]  io_imm_in,
  input wire logic        alu_req_in,
  input wire logic [2:0]  alu_op_in,
  input wire logic [15:0] accumulator_reg_in,
  input wire logic        halt_instruction_in,
  input wire logic        mem_valid_out,
  input wire logic [1:0]  seg_used_out,
  input wire logic        io_valid_out,
  input wire logic [15:0] io_addr_out,
  input wire logic        io_reserved_out,
  input wire logic        alu_valid_out,
  input wire logic        alu_write_out,
  input wire logic [15:0] flags_out,
  input wire logic        halted_out
);
  logic        mem_go;
  logic        alu_go;
  logic [15:0] high_acc;
  // Requests while halted are refused, so they start nothing
  assign mem_go   = mem_req_in && !halted_out && ref_kind_in != REF_FETCH;
  assign alu_go   = alu_req_in && !halted_out;
  assign high_acc = {8'h00, accumulator_reg_in[15:8]};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========
  // Segment choice
  a_fetch_code: assert property (
    mem_req_in && !halted_out && ref_kind_in == REF_FETCH |-> ##2
    mem_valid_out && seg_used_out == SEG_CODE) else $error("fetch off code segment");
  a_stack_select: assert property (
    mem_go && !override_in && (ref_kind_in == REF_STACK || uses_base_ptr_in) |-> ##2
    seg_used_out == SEG_STACK) else $error("stack segment not chosen");
  a_override_wins: assert property (
    mem_go && override_in |-> ##2 mem_valid_out && seg_used_out == $past(override_seg_in, 2))
    else $error("override ignored");
  // ==========
  // Port address
  a_imm_port: assert property (
    io_req_in && !halted_out && !io_use_dcount_in |=>
    io_valid_out && io_addr_out == {8'h00, $past(io_imm_in)}) else $error("port not zero-extended");
  a_reserved_port: assert property (
    io_valid_out |-> io_reserved_out == (io_addr_out >= PORT_RSVD_LO && io_addr_out <= PORT_RSVD_HI))
    else $error("reserved port flag wrong");
  // ==========
  // Flags and halt
  a_test_nowrite: assert property (
    alu_go && alu_op_in == ALU_TEST |=> alu_valid_out && !alu_write_out)
    else $error("test wrote result");
  a_flag_store: assert property (
    alu_go && alu_op_in == ALU_STORE_HIGH_ACC_TO_FLAGS |=> flags_out ==
    (($past(flags_out) & ~FLAG_STORE_MASK) | ($past(high_acc) & FLAG_STORE_MASK)))
    else $error("flag store mask wrong");
  a_halt_stop: assert property (
    halt_instruction_in && !halted_out |=> halted_out) else $error("halt not entered");
  c_extra_used: cover property (mem_valid_out && seg_used_out == SEG_EXTRA);
  c_reserved_hit: cover property (io_valid_out && io_reserved_out);
  c_wake_up: cover property (halted_out ##1 !halted_out);
endmodule
bind segment_and_io_address_select addr_select_monitor addr_select_monitor_inst (.*);

//--- bus_peripheral_model.sv
// Stand-in for memory and port devices on the system bus.
// Assumes one-cycle address strobes from the select block.
`timescale 1ns/100ps
module bus_peripheral_model (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        mem_valid_in,
  input  wire logic        io_valid_in,
  input  wire logic [15:0] io_addr_in,
  output logic      [7:0]  mem_hits_out,
  output logic      [7:0]  port_hits_out
);
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_hits_out  <= 8'h00;
      port_hits_out <= 8'h00;
    end else begin
      if (mem_valid_in) begin
        mem_hits_out <= mem_hits_out + 8'h01;
      end
      // User ports never decode in 00f8..00ff
      if (io_valid_in && io_addr_in[15:3] != 13'h001f) begin
        port_hits_out <= port_hits_out + 8'h01;
      end
    end
  end
endmodule

//--- segment_and_io_address_select_bench.sv
// Self-checking bench for the segment and I/O address select block.
// Assumes the peripheral model and bound checker are compiled first.
`timescale 1ns/100ps
module segment_and_io_address_select_bench;
  import addr_select_pkg::*;
  typedef struct packed {
    logic [3:0] kind; logic bp; logic ov; logic [1:0] oseg; logic [15:0] ofs; logic [1:0] seg;
  } mem_row_t;
  typedef struct packed {logic dc; logic [7:0] imm; logic [15:0] cnt;} io_row_t;
  logic clk_in, rstn_in, seg_wr_in, mem_req_in, uses_base_ptr_in, override_in, io_req_in;
  logic io_use_dcount_in, io_word_in, alu_req_in, alu_word_in, halt_instruction_in, irq_in;
  logic mem_valid_out, io_valid_out, io_word_out, io_reserved_out;
  logic alu_valid_out, alu_write_out, bcd_valid_out, halted_out;
  logic [1:0]  seg_wr_sel_in, override_seg_in, seg_used_out;
  logic [3:0]  ref_kind_in;
  logic [2:0]  alu_op_in;
  logic [7:0]  io_imm_in, mem_hits, port_hits;
  logic [15:0] seg_wr_data_in, offset_in, data_count_reg_in, alu_a_in, alu_b_in;
  logic [15:0] accumulator_reg_in, io_addr_out, alu_result_out, flags_out, ea;
  logic [19:0] phys_addr_out;
  logic [31:0] dword_out;
  logic [15:0] segs [4] = '{16'h1000, 16'h2000, 16'hffff, 16'h12a4};
  mem_row_t    mr;
  io_row_t     ir;
  int          mismatches = 0;
  int          checked = 0;
  // Stack segment ffff makes the stack row wrap past 1 Mbyte
  mem_row_t mem_rows [9] = '{
    '{REF_DATA, 0, 0, 0, 16'h0022, SEG_DATA}, '{REF_FETCH, 0, 1, SEG_EXTRA, 16'h0100, SEG_CODE},
    '{REF_STACK, 0, 0, 0, 16'hfff0, SEG_STACK}, '{REF_DATA, 1, 0, 0, 16'h0004, SEG_STACK},
    '{REF_STRDST, 0, 0, 0, 16'h0008, SEG_EXTRA}, '{REF_STRDST, 1, 0, 0, 16'h0010, SEG_STACK},
    '{REF_DATA, 0, 1, SEG_EXTRA, 16'h0030, SEG_EXTRA}, '{REF_STACK, 0, 1, SEG_CODE, 16'h0040, SEG_CODE},
    '{REF_STRDST, 1, 1, SEG_DATA, 16'h0050, SEG_DATA}};
  io_row_t io_rows [5] = '{'{0, 8'hf8, 16'hab00}, '{0, 8'hf7, 16'h00f8},
    '{1, 8'h00, 16'h00ff}, '{1, 8'hf8, 16'h0100}, '{1, 8'h00, 16'hfff8}};
  segment_and_io_address_select segment_and_io_address_select_inst (.*);
  bus_peripheral_model bus_peripheral_model_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .mem_valid_in(mem_valid_out), .io_valid_in(io_valid_out), .io_addr_in(io_addr_out),
    .mem_hits_out(mem_hits), .port_hits_out(port_hits));
  always #2.5 clk_in = ~clk_in;
  // ==========
  // Compare, stimulus and closing tasks
  task automatic fail(input string msg);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) fail("flag mismatch");
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
  endtask
  task automatic cmp_addr(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("address %h expected %h", got, exp));
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic alu(input logic [2:0] op, input logic w, input logic [15:0] a, b, acc);
    @(posedge clk_in);
    alu_req_in <= 1'b1;
    alu_op_in <= op;
    alu_word_in <= w;
    alu_a_in <= a;
    alu_b_in <= b;
    accumulator_reg_in <= acc;
    @(posedge clk_in);
    alu_req_in <= 1'b0;
    #1;
  endtask
  task automatic reset_check;
    cmp_bit(halted_out, 1'b0);
    cmp_word({14'h0, seg_used_out}, {14'h0, SEG_DATA});
    cmp_word(flags_out, FLAGS_RESET);
  endtask
  initial begin
    repeat (2000) @(posedge clk_in);
    mismatches++;
    print_verdict;
  end
  initial begin
    {clk_in, rstn_in, seg_wr_in, mem_req_in, uses_base_ptr_in, override_in, io_req_in} = '0;
    {io_use_dcount_in, io_word_in, alu_req_in, alu_word_in, halt_instruction_in, irq_in} = '0;
    {seg_wr_sel_in, override_seg_in, ref_kind_in, alu_op_in, io_imm_in} = '0;
    {seg_wr_data_in, offset_in, data_count_reg_in, alu_a_in, alu_b_in, accumulator_reg_in} = '0;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    reset_check();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      seg_wr_in <= (i < 4);
      seg_wr_sel_in <= i[1:0];
      seg_wr_data_in <= segs[i[1:0]];
    end
    // Back-to-back references, each answered two cycles on
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_in);
      mem_req_in <= (i < 9);
      if (i < 9) begin
        {ref_kind_in, uses_base_ptr_in, override_in, override_seg_in, offset_in} <= mem_rows[i][25:2];
      end
      #1;
      if (i >= 2 && i < 11) begin
        mr = mem_rows[i-2];
        cmp_bit(mem_valid_out, 1'b1);
        cmp_word({14'h0, seg_used_out}, {14'h0, mr.seg});
        cmp_addr(phys_addr_out, {segs[mr.seg], 4'h0} + {4'h0, mr.ofs});
      end
    end
    cmp_word({8'h00, mem_hits}, 16'h0009);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_in);
      io_req_in <= (i < 5);
      if (i < 5) begin
        {io_use_dcount_in, io_imm_in, data_count_reg_in} <= io_rows[i];
        io_word_in <= i[0];
      end
      #1;
      if (i >= 1 && i < 6) begin
        ir = io_rows[i-1];
        ea = ir.dc ? ir.cnt : {8'h00, ir.imm};
        cmp_bit(io_valid_out, 1'b1);
        cmp_word(io_addr_out, ea);
        cmp_bit(io_reserved_out, ea >= PORT_RSVD_LO && ea <= PORT_RSVD_HI);
        cmp_bit(io_word_out, ~i[0]);
      end
    end
    cmp_word({8'h00, port_hits}, 16'h0003);
    alu(ALU_TEST, 1'b1, 16'h00f0, 16'h0f0f, 16'h0000);
    cmp_bit(alu_write_out, 1'b0);
    cmp_bit(flags_out[FLAG_ZERO], 1'b1);
    alu(ALU_AND, 1'b1, 16'h00f0, 16'h00ff, 16'h0000);
    cmp_word(alu_result_out, 16'h00f0);
    alu(ALU_SUB, 1'b1, 16'h0001, 16'h0002, 16'h0000);
    cmp_word(alu_result_out, 16'hffff);
    cmp_bit(flags_out[FLAG_SIGN], 1'b1);
    alu(ALU_STORE_HIGH_ACC_TO_FLAGS, 1'b0, 16'h0000, 16'h0000, 16'hff00);
    cmp_word(flags_out, FLAG_STORE_MASK);
    alu(ALU_STORE_HIGH_ACC_TO_FLAGS, 1'b0, 16'h0000, 16'h0000, 16'h2a00);
    cmp_word(flags_out, 16'h0000);
    alu(ALU_BCD, 1'b1, 16'h0099, 16'h0000, 16'h0000);
    cmp_bit(bcd_valid_out, 1'b1);
    alu(ALU_BCD, 1'b1, 16'h00a9, 16'h0000, 16'h0000);
    cmp_bit(bcd_valid_out, 1'b0);
    alu(ALU_BCD, 1'b0, 16'h0009, 16'h0000, 16'h0000);
    cmp_bit(bcd_valid_out, 1'b1);
    alu(ALU_BCD, 1'b0, 16'h000a, 16'h0000, 16'h0000);
    cmp_bit(bcd_valid_out, 1'b0);
    @(posedge clk_in);
    data_count_reg_in <= 16'h1234;
    accumulator_reg_in <= 16'h5678;
    halt_instruction_in <= 1'b1;
    @(posedge clk_in);
    halt_instruction_in <= 1'b0;
    mem_req_in <= 1'b1;
    io_req_in <= 1'b1;
    #1;
    cmp_addr(dword_out[31:12], 20'h12345);
    cmp_word(dword_out[15:0], 16'h5678);
    cmp_bit(halted_out, 1'b1);
    @(posedge clk_in);
    mem_req_in <= 1'b0;
    io_req_in <= 1'b0;
    #1;
    cmp_bit(io_valid_out, 1'b0);
    @(posedge clk_in);
    irq_in <= 1'b1;
    #1;
    cmp_bit(mem_valid_out, 1'b0);
    for (int n = 0; n < 8 && halted_out; n++) begin
      @(posedge clk_in);
      #1;
    end
    cmp_bit(halted_out, 1'b0);
    @(posedge clk_in);
    irq_in <= 1'b0;
    // Let the synchroniser drain so the second halt is not woken at once
    repeat (3) @(posedge clk_in);
    halt_instruction_in <= 1'b1;
    @(posedge clk_in);
    halt_instruction_in <= 1'b0;
    @(posedge clk_in);
    #1;
    cmp_bit(halted_out, 1'b1);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    #1;
    reset_check();
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    print_verdict;
  end
endmodule
